// ---- ckp_defs.svh ----
// Purpose: constants of the clock and power-mode controller
// Assumes: included by the package and by the design modules
// Notes: counts are in reference-clock periods unless named otherwise
`ifndef CKP_DEFS_SVH
`define CKP_DEFS_SVH

// ---------------------------------------------------------------
// field widths
// ---------------------------------------------------------------
`define CKP_PRE_DIV_W 6
`define CKP_MAIN_DIV_W 8
`define CKP_POST_W 2
`define CKP_LOCK_W 16
`define CKP_PERIPH_N 16
`define CKP_AUX_N 3

// ---------------------------------------------------------------
// divider offsets: m = main divider + 8, p = pre-divider + 2
// ---------------------------------------------------------------
`define CKP_M_OFFSET 9'h008
`define CKP_P_OFFSET 7'h02

// ---------------------------------------------------------------
// reference select pin bits: set means external clock input
// ---------------------------------------------------------------
`define CKP_SEL_MAIN_BIT 1
`define CKP_SEL_AUX_BIT 0

// ---------------------------------------------------------------
// aux clock enable positions
// ---------------------------------------------------------------
`define CKP_AUX_USB 0
`define CKP_AUX_IRDA 1
`define CKP_AUX_CAM 2

// ---------------------------------------------------------------
// software lock-wait floor, for reference only
// ---------------------------------------------------------------
`define CKP_LOCK_MIN_US 300

`endif

// ---- ckp_pkg.sv ----
// Purpose: types shared by the clock and power-mode controller
// Assumes: ckp_defs.svh holds all numbers
// Notes: none
`include "ckp_defs.svh"

package ckp_pkg;

    // ---------------------------------------------------------------
    // pll settings as software writes them
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [`CKP_PRE_DIV_W-1:0] pre_div;
        logic [`CKP_MAIN_DIV_W-1:0] main_div;
        logic [`CKP_POST_W-1:0] post_scale;
    } ckp_pll_cfg_t;

    // effective divider values handed to the analog pll
    typedef struct packed {
        logic [`CKP_MAIN_DIV_W:0] m;
        logic [`CKP_PRE_DIV_W:0] p;
        logic [`CKP_POST_W-1:0] s;
    } ckp_pll_div_t;

    // one-cycle clock enables for the clocked blocks
    typedef struct packed {
        logic cpu;
        logic ahb;
        logic apb;
        logic usb;
        logic infrared;
        logic camera;
    } ckp_clk_en_t;

    typedef enum logic [2:0] {
        CKP_BOOT,
        CKP_LOCK,
        CKP_RAW,
        CKP_RUN,
        CKP_STOP,
        CKP_SLEEP
    } ckp_state_t;

endpackage

// ---- ckp_lock_counter.sv ----
// Purpose: lock-wait counter for one pll
// Assumes: ref_tick is a one-cycle pulse per reference period
// Notes: busy falls only on a clk_sys edge, so release is glitch-free
`timescale 1ns/1ns
`include "ckp_defs.svh"

module ckp_lock_counter (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic start,
    input wire logic ref_tick,
    input wire logic [`CKP_LOCK_W-1:0] lock_count,
    output logic busy
);
    import ckp_pkg::*;

    logic [`CKP_LOCK_W-1:0] remaining;

    // ---------------------------------------------------------------
    // load on trigger, count down one per reference period
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            remaining <= '0;
        end else if (start) begin
            remaining <= lock_count;
        end else if (ref_tick && remaining != '0) begin
            remaining <= remaining - `CKP_LOCK_W'(1);
        end
    end

    assign busy = (remaining != '0);

endmodule // ckp_lock_counter

// ---- ckp_clock_power.sv ----
// Purpose: reference select, pll switchover, lock wait and power-mode gating
// Assumes: pll ticks are same-domain enables from the analog pll wrappers
// Notes: every clock leaves as a one-cycle enable on clk_sys
`timescale 1ns/1ns
`include "ckp_defs.svh"

module ckp_clock_power (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [1:0] ref_source_select_pins,
    input wire logic crystal_input,
    input wire logic external_clock_input,
    input wire logic wake_up_pin,
    input wire logic main_pll_tick,
    input wire logic aux_pll_tick,
    input wire logic main_pll_config_wr,
    input wire ckp_pkg::ckp_pll_cfg_t main_pll_config,
    input wire logic aux_pll_config_wr,
    input wire ckp_pkg::ckp_pll_cfg_t aux_pll_config,
    input wire logic [`CKP_LOCK_W-1:0] main_lock_count,
    input wire logic [`CKP_LOCK_W-1:0] aux_lock_count,
    input wire logic slow_mode,
    input wire logic idle_mode_bit,
    input wire logic stop_mode_bit,
    input wire logic sleep_mode_bit,
    input wire logic [`CKP_PERIPH_N-1:0] periph_clock_enable,
    input wire logic [`CKP_AUX_N-1:0] aux_clock_enable,
    output ckp_pkg::ckp_clk_en_t clock_enables,
    output logic [`CKP_PERIPH_N-1:0] periph_clk_en,
    output ckp_pkg::ckp_pll_div_t main_pll_div,
    output ckp_pkg::ckp_pll_div_t aux_pll_div,
    output logic main_pll_power_down,
    output logic aux_pll_power_down,
    output logic internal_power_off,
    output logic main_on_pll,
    output logic aux_on_pll,
    output logic idle_active
);
    import ckp_pkg::*;

    // effective dividers: the analog pll multiplies by m and divides by p*2^s
    function automatic ckp_pll_div_t to_div(input ckp_pll_cfg_t cfg);
        ckp_pll_div_t d;
        d.m = {1'b0, cfg.main_div} + `CKP_M_OFFSET;
        d.p = {1'b0, cfg.pre_div} + `CKP_P_OFFSET;
        d.s = cfg.post_scale;
        return d;
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] ref_sync [2];
    logic [1:0] ref_tick;
    logic [1:0] sel_meta;
    logic [1:0] sel_sync;
    logic wake_meta;
    logic wake;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_ref
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    // ones, so a pin already high at release gives no false tick
                    ref_sync[i] <= 3'h7;
                end else begin
                    ref_sync[i] <= {ref_sync[i][1:0], (i == 0) ? crystal_input
                                                               : external_clock_input};
                end
            end
            // rising edge seen on the synchronised copies only
            assign ref_tick[i] = ref_sync[i][1] & ~ref_sync[i][2];
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sel_meta <= 2'h0;
            sel_sync <= 2'h0;
            wake_meta <= 1'b0;
            wake <= 1'b0;
        end else begin
            sel_meta <= ref_source_select_pins;
            sel_sync <= sel_meta;
            wake_meta <= wake_up_pin;
            wake <= wake_meta;
        end
    end

    // bit set means external clock, crystal otherwise
    logic main_ref_tick;
    logic aux_ref_tick;
    assign main_ref_tick = ref_tick[sel_sync[`CKP_SEL_MAIN_BIT]];
    assign aux_ref_tick = ref_tick[sel_sync[`CKP_SEL_AUX_BIT]];

    // ---------------------------------------------------------------
    // mode bit edge detection: only low-to-high triggers a mode
    // ---------------------------------------------------------------
    logic idle_prev;
    logic stop_prev;
    logic sleep_prev;
    logic idle_rise;
    logic stop_rise;
    logic sleep_rise;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            idle_prev <= 1'b0;
            stop_prev <= 1'b0;
            sleep_prev <= 1'b0;
        end else begin
            idle_prev <= idle_mode_bit;
            stop_prev <= stop_mode_bit;
            sleep_prev <= sleep_mode_bit;
        end
    end

    assign idle_rise = idle_mode_bit & ~idle_prev;
    assign stop_rise = stop_mode_bit & ~stop_prev;
    assign sleep_rise = sleep_mode_bit & ~sleep_prev;

    // ---------------------------------------------------------------
    // lock counters, one per pll
    // ---------------------------------------------------------------
    ckp_state_t state;
    ckp_state_t next_state;
    logic main_valid;
    logic aux_valid;
    logic [1:0] lock_start;
    logic [1:0] lock_tick;
    logic [1:0] lock_busy;
    logic [`CKP_LOCK_W-1:0] lock_count [2];
    logic woke;
    logic down_mode;

    assign down_mode = (state == CKP_STOP) || (state == CKP_SLEEP);
    assign woke = down_mode && wake;
    assign lock_count[0] = main_lock_count;
    assign lock_count[1] = aux_lock_count;
    assign lock_tick[0] = main_ref_tick;
    assign lock_tick[1] = aux_ref_tick;
    // reset release and wake both restart the wait, not only a write
    assign lock_start[0] = (state == CKP_BOOT) || woke
                           || (main_pll_config_wr && !down_mode);
    assign lock_start[1] = (state == CKP_BOOT) || woke
                           || (aux_pll_config_wr && !down_mode);

    generate
        for (genvar i = 0; i < 2; i++) begin : g_lock
            ckp_lock_counter u_lock (
                .clk_sys(clk_sys),
                .reset(reset),
                .start(lock_start[i]),
                .ref_tick(lock_tick[i]),
                .lock_count(lock_count[i]),
                .busy(lock_busy[i])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // main sequencer
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            CKP_BOOT: next_state = CKP_LOCK;
            CKP_LOCK: begin
                if (!main_pll_config_wr && !lock_busy[0]) begin
                    next_state = main_valid ? CKP_RUN : CKP_RAW;
                end
            end
            CKP_RAW, CKP_RUN: begin
                if (sleep_rise) begin
                    next_state = CKP_SLEEP;
                end else if (stop_rise) begin
                    next_state = CKP_STOP;
                end else if (main_pll_config_wr) begin
                    next_state = CKP_LOCK;
                end
            end
            CKP_STOP, CKP_SLEEP: begin
                if (wake) begin
                    next_state = CKP_LOCK;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= CKP_BOOT;
        end else begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // pll settings and switchover flags
    // ---------------------------------------------------------------
    ckp_pll_cfg_t main_cfg;
    ckp_pll_cfg_t aux_cfg;

    // the pll output is trusted only once software has written settings
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            main_valid <= 1'b0;
            main_cfg <= '0;
        end else if (main_pll_config_wr && !down_mode) begin
            main_valid <= 1'b1;
            main_cfg <= main_pll_config;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aux_valid <= 1'b0;
            aux_cfg <= '0;
        end else if (aux_pll_config_wr && !down_mode) begin
            aux_valid <= 1'b1;
            aux_cfg <= aux_pll_config;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            main_pll_div <= '0;
            aux_pll_div <= '0;
        end else begin
            main_pll_div <= to_div(main_cfg);
            aux_pll_div <= to_div(aux_cfg);
        end
    end

    // ---------------------------------------------------------------
    // idle flag: cleared by wake-up
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            idle_active <= 1'b0;
        end else if (idle_rise && (state == CKP_RAW || state == CKP_RUN)) begin
            idle_active <= 1'b1;
        end else if (wake) begin
            idle_active <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // clock source and gating
    // ---------------------------------------------------------------
    logic use_main_pll;
    logic main_src_tick;
    logic aux_src_tick;
    logic main_run;
    logic aux_run;

    // slow mode trades speed for power by running straight from the reference
    assign use_main_pll = (state == CKP_RUN) && main_valid && !slow_mode;
    assign main_src_tick = use_main_pll ? main_pll_tick : main_ref_tick;
    assign aux_src_tick = aux_valid ? aux_pll_tick : aux_ref_tick;
    assign main_run = (state == CKP_RAW) || (state == CKP_RUN);
    assign aux_run = !down_mode && (state != CKP_BOOT) && !lock_busy[1];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            clock_enables <= '0;
        end else begin
            clock_enables.cpu <= main_run && !idle_active && main_src_tick;
            clock_enables.ahb <= main_run && main_src_tick;
            clock_enables.apb <= main_run && main_src_tick;
            clock_enables.usb <= aux_run && aux_src_tick
                                 && aux_clock_enable[`CKP_AUX_USB];
            clock_enables.infrared <= aux_run && aux_src_tick
                                      && aux_clock_enable[`CKP_AUX_IRDA];
            clock_enables.camera <= aux_run && aux_src_tick
                                    && aux_clock_enable[`CKP_AUX_CAM];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            periph_clk_en <= '0;
        end else if (main_run && main_src_tick) begin
            periph_clk_en <= periph_clock_enable;
        end else begin
            periph_clk_en <= '0;
        end
    end

    // ---------------------------------------------------------------
    // power controls and status
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            main_pll_power_down <= 1'b0;
            aux_pll_power_down <= 1'b0;
            internal_power_off <= 1'b0;
            main_on_pll <= 1'b0;
            aux_on_pll <= 1'b0;
        end else begin
            main_pll_power_down <= down_mode && !wake;
            aux_pll_power_down <= down_mode && !wake;
            internal_power_off <= (state == CKP_SLEEP) && !wake;
            main_on_pll <= use_main_pll;
            aux_on_pll <= aux_valid && aux_run;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_ref_select;
        (state == CKP_RAW) && !idle_active && (sel_sync[1] ? ref_tick[1] : ref_tick[0])
            |=> clock_enables.cpu;
    endproperty
    a_ref_select: assert property (p_ref_select) else $error("main ref source wrong");

    property p_raw_before_write;
        !main_valid |=> !main_on_pll;
    endproperty
    a_raw_before_write: assert property (p_raw_before_write)
        else $error("pll used before configuration");

    property p_cpu_gated_in_lock;
        (state == CKP_LOCK) |=> !clock_enables.cpu && !clock_enables.ahb;
    endproperty
    a_cpu_gated_in_lock: assert property (p_cpu_gated_in_lock)
        else $error("clock leaked during lock wait");

    property p_write_locks;
        (state == CKP_RUN) && main_pll_config_wr && !sleep_rise && !stop_rise
            |=> (state == CKP_LOCK) ##1 lock_busy[0] || (state != CKP_LOCK);
    endproperty
    a_write_locks: assert property (p_write_locks) else $error("write did not lock");

    property p_lock_release;
        (state == CKP_LOCK) && !lock_busy[0] && !main_pll_config_wr
            |=> (state == CKP_RUN) || (state == CKP_RAW);
    endproperty
    a_lock_release: assert property (p_lock_release) else $error("lock not released");

    property p_idle_cpu_only;
        idle_active && main_run && main_src_tick |=> !clock_enables.cpu && clock_enables.ahb;
    endproperty
    a_idle_cpu_only: assert property (p_idle_cpu_only) else $error("idle gating wrong");

    property p_stop_frozen;
        (state == CKP_STOP) && !wake |=> main_pll_power_down && (clock_enables == '0)
            && (periph_clk_en == '0);
    endproperty
    a_stop_frozen: assert property (p_stop_frozen) else $error("stop left a clock on");

    property p_aux_off;
        (stop_rise || sleep_rise) && main_run ##1 !wake |=> aux_pll_power_down;
    endproperty
    a_aux_off: assert property (p_aux_off) else $error("aux pll not powered down");

    property p_sleep_power;
        sleep_rise && main_run ##1 !wake |=> internal_power_off;
    endproperty
    a_sleep_power: assert property (p_sleep_power) else $error("sleep supply not off");

    property p_periph_follow;
        main_run && main_src_tick |=> periph_clk_en == $past(periph_clock_enable);
    endproperty
    a_periph_follow: assert property (p_periph_follow) else $error("peripheral gate wrong");

    property p_boot_lock;
        (state == CKP_BOOT) |=> (state == CKP_LOCK);
    endproperty
    a_boot_lock: assert property (p_boot_lock) else $error("no lock after reset");

endmodule // ckp_clock_power

// ---- ckp_ref_model.sv ----
// Purpose: reference pins and pll tick sources beside the clock controller
// Assumes: pll ticks are one clk_sys pulse per pll period
// Notes: crystal and external run at unrelated rates so the chosen source shows in counts
`timescale 1ns/1ns

module ckp_ref_model (
    input wire logic clk_sys,
    input wire logic main_pll_power_down,
    input wire logic aux_pll_power_down,
    output logic crystal_input,
    output logic external_clock_input,
    output logic main_pll_tick,
    output logic aux_pll_tick
);
    logic [1:0] main_div = 2'h0;
    logic [2:0] aux_div = 3'h0;

    // ---------------------------------------------------------------
    // free-running references, out of phase with clk_sys
    // ---------------------------------------------------------------
    initial begin
        crystal_input = 1'b0;
        #3;
        forever #20 crystal_input = ~crystal_input;
    end

    initial begin
        external_clock_input = 1'b0;
        #7;
        forever #12 external_clock_input = ~external_clock_input;
    end

    // ---------------------------------------------------------------
    // pll outputs: main every 3 cycles, aux every 5
    // ---------------------------------------------------------------
    initial begin
        main_pll_tick = 1'b0;
        aux_pll_tick = 1'b0;
    end

    // a powered-down pll gives no output at all, so leaked enables show up
    always @(posedge clk_sys) begin
        main_div <= (main_div == 2'h2) ? 2'h0 : main_div + 2'h1;
        aux_div <= (aux_div == 3'h4) ? 3'h0 : aux_div + 3'h1;
        main_pll_tick <= (main_div == 2'h2) && !main_pll_power_down;
        aux_pll_tick <= (aux_div == 3'h4) && !aux_pll_power_down;
    end
endmodule // ckp_ref_model

// ---- pll_clock_source_and_power_modes_tb_top.sv ----
// Purpose: self-checking bench of the clock and power-mode controller
// Assumes: crystal 10 cycles, external 6, main pll 3, aux pll 5 cycles per tick
// Notes: pulse counts allow one tick of slack for phase
`timescale 1ns/1ns
`include "ckp_defs.svh"

module pll_clock_source_and_power_modes_tb_top;
    import ckp_pkg::*;
    logic clk_sys, reset, wake_up_pin, main_pll_config_wr, aux_pll_config_wr, slow_mode;
    logic [1:0] ref_source_select_pins;
    logic crystal_input, external_clock_input, main_pll_tick, aux_pll_tick;
    ckp_pll_cfg_t main_pll_config, aux_pll_config;
    logic [`CKP_LOCK_W-1:0] main_lock_count, aux_lock_count;
    logic idle_mode_bit, stop_mode_bit, sleep_mode_bit;
    logic [`CKP_PERIPH_N-1:0] periph_clock_enable, periph_clk_en, seen_periph;
    logic [`CKP_AUX_N-1:0] aux_clock_enable;
    ckp_clk_en_t clock_enables;
    ckp_pll_div_t main_pll_div, aux_pll_div;
    logic main_pll_power_down, aux_pll_power_down, internal_power_off;
    logic main_on_pll, aux_on_pll, idle_active;
    logic [31:0] n_cpu, n_ahb, n_usb, n_odd;
    int n_fail = 0;
    int compares = 0;

    ckp_clock_power dut_u (.clk_sys, .reset, .ref_source_select_pins, .crystal_input,
        .external_clock_input, .wake_up_pin, .main_pll_tick, .aux_pll_tick,
        .main_pll_config_wr, .main_pll_config, .aux_pll_config_wr, .aux_pll_config,
        .main_lock_count, .aux_lock_count, .slow_mode, .idle_mode_bit, .stop_mode_bit,
        .sleep_mode_bit, .periph_clock_enable, .aux_clock_enable, .clock_enables,
        .periph_clk_en, .main_pll_div, .aux_pll_div, .main_pll_power_down,
        .aux_pll_power_down, .internal_power_off, .main_on_pll, .aux_on_pll, .idle_active);

    ckp_ref_model ref_u (.clk_sys, .main_pll_power_down, .aux_pll_power_down,
        .crystal_input, .external_clock_input, .main_pll_tick, .aux_pll_tick);

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic near(input logic [31:0] v, input logic [31:0] e);
        return (v + 32'h1 >= e) && (v <= e + 32'h1);
    endfunction

    task automatic count(input int n);
        n_cpu = '0;
        n_ahb = '0;
        n_usb = '0;
        n_odd = '0;
        seen_periph = '0;
        repeat (n) begin
            @(negedge clk_sys);
            n_cpu = n_cpu + clock_enables.cpu;
            n_ahb = n_ahb + clock_enables.ahb;
            n_usb = n_usb + clock_enables.usb;
            n_odd = n_odd + (clock_enables.apb ^ clock_enables.ahb)
                + (clock_enables.infrared ^ clock_enables.usb)
                + (clock_enables.camera ^ clock_enables.usb);
            seen_periph = seen_periph | periph_clk_en;
        end
    endtask

    task automatic do_reset(input logic [1:0] sel);
        @(posedge clk_sys);
        reset <= 1'b1;
        ref_source_select_pins <= sel;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
    endtask

    // returns on the negedge one cycle after the edge where the new divider values land
    task automatic wr_cfg(input logic aux, input ckp_pll_cfg_t cfg);
        @(posedge clk_sys);
        main_pll_config_wr <= !aux;
        aux_pll_config_wr <= aux;
        main_pll_config <= cfg;
        aux_pll_config <= cfg;
        @(posedge clk_sys);
        main_pll_config_wr <= 1'b0;
        aux_pll_config_wr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic wait_on(input logic aux);
        for (int i = 0; i < 500 && ((aux ? aux_on_pll : main_on_pll) !== 1'b1); i++) begin
            @(negedge clk_sys);
        end
    endtask

    // wake level is held long enough for the two-flop synchroniser
    task automatic wake;
        @(posedge clk_sys);
        wake_up_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        wake_up_pin <= 1'b0;
        idle_mode_bit <= 1'b0;
        stop_mode_bit <= 1'b0;
        sleep_mode_bit <= 1'b0;
    endtask

    task automatic conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // clock, watchdog and test sequence
    // ---------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        #100000;
        n_fail++;
        conclude();
    end

    initial begin
        reset = 1'b1;
        {wake_up_pin, main_pll_config_wr, aux_pll_config_wr, slow_mode} = 4'h0;
        {idle_mode_bit, stop_mode_bit, sleep_mode_bit} = 3'h0;
        ref_source_select_pins = 2'h0;
        main_pll_config = '0;
        aux_pll_config = '0;
        main_lock_count = 16'h0003;
        aux_lock_count = 16'h0004;
        periph_clock_enable = 16'hFFFF;
        aux_clock_enable = 3'h7;
        for (int c = 3; c >= 0; c--) begin
            do_reset(c[1:0]);
            count(10);
            check(n_cpu + n_usb, 32'h0);
            repeat (60) @(posedge clk_sys);
            count(240);
            check(near(n_cpu, c[1] ? 32'h28 : 32'h18), 1'b1);
            check(near(n_usb, c[0] ? 32'h28 : 32'h18), 1'b1);
            check(main_on_pll, 1'b0);
        end
        slow_mode <= 1'b1;
        wr_cfg(1'b0, '0);
        repeat (80) @(posedge clk_sys);
        count(120);
        check(near(n_cpu, 32'h0C), 1'b1);
        check(main_on_pll, 1'b0);
        slow_mode <= 1'b0;
        wr_cfg(1'b0, '{pre_div: 6'h3F, main_div: 8'hFF, post_scale: 2'h3});
        check(main_pll_div, {9'h107, 7'h41, 2'h3});
        count(16);
        check(n_cpu + n_ahb, 32'h0);
        wait_on(1'b0);
        check(main_on_pll, 1'b1);
        count(120);
        check(near(n_cpu, 32'h28), 1'b1);
        wr_cfg(1'b1, '0);
        check(aux_pll_div, {9'h008, 7'h02, 2'h0});
        count(16);
        check({n_usb == 0, n_cpu > 0}, 2'b11);
        wait_on(1'b1);
        check(aux_on_pll, 1'b1);
        count(120);
        check(near(n_usb, 32'h18), 1'b1);
        check(n_odd, 32'h0);
        periph_clock_enable <= 16'h00FF;
        count(60);
        check(seen_periph, 16'h00FF);
        idle_mode_bit <= 1'b1;
        repeat (4) @(posedge clk_sys);
        count(60);
        check({idle_active, n_cpu == 0, n_ahb > 0, n_usb > 0}, 4'hF);
        wake();
        repeat (10) @(posedge clk_sys);
        check(idle_active, 1'b0);
        stop_mode_bit <= 1'b1;
        repeat (4) @(posedge clk_sys);
        count(40);
        check({main_pll_power_down, aux_pll_power_down, internal_power_off}, 3'b110);
        check(n_cpu + n_ahb + n_usb + seen_periph, 32'h0);
        wake();
        wait_on(1'b0);
        check({main_on_pll, main_pll_power_down, aux_pll_power_down}, 3'b100);
        sleep_mode_bit <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check({main_pll_power_down, aux_pll_power_down, internal_power_off}, 3'b111);
        wr_cfg(1'b0, '{pre_div: 6'h01, main_div: 8'h10, post_scale: 2'h1});
        check(main_pll_div, {9'h107, 7'h41, 2'h3});
        wake();
        wait_on(1'b0);
        check({main_on_pll, internal_power_off}, 2'b10);
        conclude();
    end
endmodule // pll_clock_source_and_power_modes_tb_top
